/* File: hdl/bits_seq.sv */
// Function
// (R1) Device number from register; start at effective address, end in following halfword.
// (R2) Block input stores each received byte at successive memory bytes.
// (R3) Block output fetches successive memory bytes and sends each to device.
// (R4) After each byte, read status byte and examine only its high nibble.
// (R5) While busy bit 4 is set, repeat status reads without data transfer.
// (R6) Busy clear and any of bits 5-7 set ends operation, bits kept.
// (R7) All four bits clear continues with next byte unless address ends.
// (R8) Normal finish when current address equals end; condition code reads zero.
// (R9) Input: good status, no match, increment address and repeat cycle.
// (R10) Output: good status, compare addresses, stop if equal else increment, repeat.
// (R11) Device addressed once; then data and status lines alternate.
// (R12) Last examined status bits stay in condition code after the end.
// (R13) Register variants take start address from second register operand.
// (R14) Status request raised; controller returns byte with sync; drop request, sync drops.
// (R15) Status bits 4-7 copied into condition code on each status byte.
// (R16) Controller holds busy until the data byte is settled.
`timescale 1ns/1ps
module bits_seq
    import bits_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Byte memory port, read data taken in the same cycle the request is presented.
    output bits_mem_req_type mem_req,
    input wire logic [7:0] mem_rdata,
    // I/O bus.
    output bits_io_ctl_type io_ctl,
    input wire logic [7:0] return_data_lines,
    input wire logic sync_response,
    // Interrupt.
    output logic irq
);
    bits_state_type st_q, st_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [7:0] dev_q, dev_d;
    logic [15:0] regstart_q, regstart_d, ea_q, ea_d, end_q, end_d, cur_q, cur_d;
    logic [7:0] byte_q, byte_d;
    logic [3:0] cc_q, cc_d;
    logic [2:0] ev_q, ev_d, mask_q, mask_d;
    logic busy_q, busy_d, ph_q, ph_d;
    bits_mem_req_type mem_q, mem_d;
    bits_io_ctl_type io_q, io_d;
    logic [7:0] rdl_s1_q, rdl_s2_q;
    logic syn_s1_q, syn_s2_q;
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, irq_q, irq_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [2:0] ev_set;
    logic go_refused;

    // Two-flop synchronisers for the bus inputs.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdl_s1_q <= 8'h00;
            rdl_s2_q <= 8'h00;
            syn_s1_q <= 1'b0;
            syn_s2_q <= 1'b0;
        end else begin
            rdl_s1_q <= return_data_lines;
            rdl_s2_q <= rdl_s1_q;
            syn_s1_q <= sync_response;
            syn_s2_q <= syn_s1_q;
        end
    end

    // Sequencer.
    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        end_d = end_q;
        byte_d = byte_q;
        cc_d = cc_q;
        busy_d = busy_q;
        ph_d = 1'b0;
        mem_d = '0;
        io_d = io_q;
        ev_set = 3'h0;
        unique case (st_q)
            ST_IDLE: begin
                if (ctrl_q[CTRL_GO] && !busy_q) begin
                    busy_d = 1'b1;
                    // Register form uses the second register operand directly.
                    if (ctrl_q[CTRL_REGF]) begin // [R13]
                        cur_d = regstart_q;
                        mem_d.rd = 1'b1;
                        mem_d.addr = ea_q; // [R1]
                        st_d = ST_FETCH_E;
                    end else begin
                        mem_d.rd = 1'b1;
                        mem_d.addr = ea_q; // [R1]
                        st_d = ST_FETCH_S;
                    end
                end
            end
            ST_FETCH_S: begin
                // Two byte reads build the start halfword, high byte first.
                if (!ph_q) begin
                    cur_d[15:8] = mem_rdata;
                    mem_d.rd = 1'b1;
                    mem_d.addr = ea_q + ADDR_ONE;
                    ph_d = 1'b1;
                end else begin
                    cur_d[7:0] = mem_rdata;
                    mem_d.rd = 1'b1;
                    mem_d.addr = ea_q + 16'h0002; // [R1]
                    st_d = ST_FETCH_E;
                end
            end
            ST_FETCH_E: begin
                if (!ph_q) begin
                    end_d[15:8] = mem_rdata;
                    mem_d.rd = 1'b1;
                    mem_d.addr = (ctrl_q[CTRL_REGF] ? ea_q : ea_q + 16'h0002) + ADDR_ONE;
                    ph_d = 1'b1;
                end else begin
                    end_d[7:0] = mem_rdata;
                    io_d.dal = dev_q; // [R1]
                    io_d.adrs = 1'b1; // [R11]
                    st_d = ST_ADDR;
                end
            end
            ST_ADDR: if (syn_s2_q) begin
                io_d.adrs = 1'b0;
                st_d = ST_ADDR_REL;
            end
            ST_ADDR_REL: if (!syn_s2_q) begin
                if (ctrl_q[CTRL_OUT]) begin
                    mem_d.rd = 1'b1;
                    mem_d.addr = cur_q; // [R3]
                    st_d = ST_MRD;
                end else begin
                    io_d.data_request_line = 1'b1; // [R2]
                    st_d = ST_DATA;
                end
            end
            ST_MRD: begin
                io_d.dal = mem_rdata; // [R3]
                io_d.data_output_line = 1'b1;
                st_d = ST_DATA;
            end
            ST_DATA: if (syn_s2_q) begin
                byte_d = rdl_s2_q;
                io_d.data_request_line = 1'b0;
                io_d.data_output_line = 1'b0;
                st_d = ST_DATA_REL;
            end
            ST_DATA_REL: if (!syn_s2_q) begin
                if (!ctrl_q[CTRL_OUT]) begin
                    mem_d.wr = 1'b1; // [R2]
                    mem_d.addr = cur_q;
                    mem_d.wdata = byte_q;
                end
                io_d.status_request_line = 1'b1; // [R4] [R11] [R14]
                st_d = ST_STAT;
            end
            ST_STAT: if (syn_s2_q) begin
                cc_d = rdl_s2_q[ST_ERR_HI:ST_BUSY]; // [R4] [R15]
                io_d.status_request_line = 1'b0; // [R14]
                st_d = ST_STAT_REL;
            end
            ST_STAT_REL: if (!syn_s2_q) begin
                st_d = ST_CHECK;
            end
            ST_CHECK: begin
                if (cc_q[0]) begin
                    io_d.status_request_line = 1'b1; // [R5]
                    st_d = ST_STAT;
                end else if (cc_q[ST_ERR_HI-ST_BUSY:ST_ERR_LO-ST_BUSY] != 3'h0) begin
                    ev_set[EV_ERR] = 1'b1; // [R6] [R12]
                    busy_d = 1'b0;
                    st_d = ST_IDLE;
                end else if (cur_q == end_q) begin
                    ev_set[EV_DONE] = 1'b1; // [R8] [R10]
                    busy_d = 1'b0;
                    st_d = ST_IDLE;
                end else begin
                    cur_d = cur_q + ADDR_ONE; // [R7] [R9] [R10]
                    st_d = ST_MWR;
                end
            end
            ST_MWR: begin
                if (ctrl_q[CTRL_OUT]) begin
                    mem_d.rd = 1'b1;
                    mem_d.addr = cur_q; // [R3]
                    st_d = ST_MRD;
                end else begin
                    io_d.data_request_line = 1'b1; // [R9] [R11]
                    st_d = ST_DATA;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // AXI4-Lite slave and registers.
    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        ctrl_d = ctrl_q;
        ctrl_d[CTRL_GO] = 1'b0;
        dev_d = dev_q;
        regstart_d = regstart_q;
        ea_d = ea_q;
        mask_d = mask_q;
        ev_d = ev_q;
        go_refused = 1'b0;
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (aw_q && w_q && !bv_q) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = RESP_OKAY;
            unique case (awa_q)
                REG_CTRL: begin
                    // A write while busy is ignored so the running mode cannot change.
                    go_refused = busy_q && wd_q[CTRL_GO];
                    if (!busy_q) ctrl_d = wd_q[2:0];
                end
                REG_DEVNUM: dev_d = wd_q[7:0];
                REG_START: regstart_d = wd_q[15:0];
                REG_END: ea_d = wd_q[15:0];
                REG_MASK: mask_d = wd_q[2:0];
                REG_CUR, REG_STAT, REG_IRQ: br_d = RESP_OKAY;
                default: br_d = RESP_SLVERR;
            endcase
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
        if (rv_q && s_axi_rready) rv_d = 1'b0;
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            rd_d = 32'h0;
            unique case (s_axi_araddr)
                REG_CTRL: rd_d[2:0] = ctrl_q;
                REG_DEVNUM: rd_d[7:0] = dev_q;
                REG_START: rd_d[15:0] = regstart_q;
                REG_END: rd_d[15:0] = ea_q;
                REG_CUR: rd_d[15:0] = cur_q;
                REG_STAT: rd_d = {23'h0, busy_q, cc_q, 4'h0}; // [R12]
                REG_IRQ: rd_d[2:0] = ev_q;
                REG_MASK: rd_d[2:0] = mask_q;
                default: rr_d = RESP_SLVERR;
            endcase
            // Read of the event register clears it; a new event still wins.
            if (s_axi_araddr == REG_IRQ) ev_d = 3'h0;
        end
        ev_d = ev_d | ev_set;
        ev_d[EV_W] = ev_d[EV_W] | go_refused;
        irq_d = |(ev_d & mask_q);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            ctrl_q <= 3'h0;
            dev_q <= 8'h00;
            regstart_q <= 16'h0000;
            ea_q <= 16'h0000;
            end_q <= 16'h0000;
            cur_q <= 16'h0000;
            byte_q <= 8'h00;
            cc_q <= 4'h0;
            busy_q <= 1'b0;
            ph_q <= 1'b0;
            mem_q <= '0;
            io_q <= '0;
            ev_q <= 3'h0;
            mask_q <= 3'h0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rr_q <= 2'h0;
            rd_q <= 32'h0;
            irq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            dev_q <= dev_d;
            regstart_q <= regstart_d;
            ea_q <= ea_d;
            end_q <= end_d;
            cur_q <= cur_d;
            byte_q <= byte_d;
            cc_q <= cc_d;
            busy_q <= busy_d;
            ph_q <= ph_d;
            mem_q <= mem_d;
            io_q <= io_d;
            ev_q <= ev_d;
            mask_q <= mask_d;
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
            irq_q <= irq_d;
        end
    end

    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rresp = rr_q;
    assign s_axi_rdata = rd_q;
    assign mem_req = mem_q;
    assign io_ctl = io_q;
    assign irq = irq_q;

    // Checks.
    a_busy_repoll: assert property (@(posedge clk) disable iff (!rstn) // [R5]
        (st_q == ST_CHECK && cc_q[0]) |=> (st_q == ST_STAT && io_q.status_request_line))
        else $error("busy status did not re-poll");
    a_err_stop: assert property (@(posedge clk) disable iff (!rstn) // [R6]
        (st_q == ST_CHECK && !cc_q[0] && cc_q[3:1] != 3'h0) |=> (st_q == ST_IDLE && ev_q[EV_ERR]))
        else $error("error status did not stop");
    a_done_stop: assert property (@(posedge clk) disable iff (!rstn) // [R8]
        (st_q == ST_CHECK && cc_q == 4'h0 && cur_q == end_q) |=> (st_q == ST_IDLE && cc_q == 4'h0))
        else $error("normal finish wrong");
    a_addr_incr: assert property (@(posedge clk) disable iff (!rstn) // [R9]
        (st_q == ST_CHECK && cc_q == 4'h0 && cur_q != end_q) |=> (cur_q == $past(cur_q) + 16'h0001))
        else $error("address not incremented");
    a_stat_copy: assert property (@(posedge clk) disable iff (!rstn) // [R15]
        (st_q == ST_STAT && syn_s2_q) |=> (cc_q == $past(rdl_s2_q[7:4])))
        else $error("status not copied");
    a_one_line: assert property (@(posedge clk) disable iff (!rstn) // [R11]
        $onehot0({io_q.adrs, io_q.data_request_line, io_q.data_output_line,
        io_q.status_request_line}))
        else $error("two control lines high");
    a_sr_drop: assert property (@(posedge clk) disable iff (!rstn) // [R14]
        (io_q.status_request_line && syn_s2_q) |=> !io_q.status_request_line)
        else $error("status request not dropped");
    a_in_store: assert property (@(posedge clk) disable iff (!rstn) // [R2]
        (st_q == ST_DATA_REL && !syn_s2_q && !ctrl_q[CTRL_OUT]) |=> (mem_q.wr && mem_q.addr == cur_q))
        else $error("input byte not stored");
endmodule

/* File: hdl/bits_pkg.sv */
package bits_pkg;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DEVNUM = 8'h04;
    localparam logic [7:0] REG_START = 8'h08;
    localparam logic [7:0] REG_END = 8'h0c;
    localparam logic [7:0] REG_CUR = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_IRQ = 8'h18;
    localparam logic [7:0] REG_MASK = 8'h1c;
    // Control field positions.
    localparam int CTRL_GO = 0;
    localparam int CTRL_OUT = 1;
    localparam int CTRL_REGF = 2;
    // Status byte bit positions.
    localparam int ST_BUSY = 4;
    localparam int ST_ERR_LO = 5;
    localparam int ST_ERR_HI = 7;
    // Event bit positions.
    localparam int EV_DONE = 0;
    localparam int EV_ERR = 1;
    localparam int EV_W = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] ADDR_ONE = 16'h0001;
    // Memory port request.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bits_mem_req_type;
    // I/O bus control lines toward the controller.
    typedef struct packed {
        logic adrs;
        logic data_request_line;
        logic data_output_line;
        logic status_request_line;
        logic [7:0] dal;
    } bits_io_ctl_type;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_FETCH_S = 4'h1,
        ST_FETCH_E = 4'h2,
        ST_ADDR = 4'h3,
        ST_ADDR_REL = 4'h4,
        ST_MRD = 4'h5,
        ST_DATA = 4'h6,
        ST_DATA_REL = 4'h7,
        ST_STAT = 4'h8,
        ST_STAT_REL = 4'h9,
        ST_CHECK = 4'ha,
        ST_MWR = 4'hb
    } bits_state_type;
endpackage

/* File: testbench/bits_io_model.sv */
`timescale 1ns/1ps
module bits_io_model
    import bits_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Memory side.
    input wire bits_mem_req_type mem_req,
    output logic [7:0] mem_rdata,
    // Controller side.
    input wire bits_io_ctl_type io_ctl,
    output logic [7:0] return_data_lines,
    output logic sync_response
);
    logic [7:0] mem [0:65535];
    logic [7:0] in_bytes [0:15];
    logic [7:0] out_bytes [0:15];
    logic [7:0] err_stat;
    logic [7:0] dev_seen;
    logic [7:0] rdl;
    logic [3:0] junk;
    int busy_polls;
    int err_byte;
    int lag;
    int polls;
    int nbyte;
    int n_adrs;
    int n_stat;
    logic [7:0] idle_q = 8'h00;
    wire any_line = io_ctl.adrs | io_ctl.data_request_line | io_ctl.data_output_line
        | io_ctl.status_request_line;

    // Byte memory answers while the registered read request stands; idle data toggles.
    always @(posedge clk) begin
        idle_q <= ~idle_q;
        if (mem_req.wr) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
    end
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : idle_q;

    // Controller answers each control line with a sync response.
    initial begin
        return_data_lines = 8'h00;
        sync_response = 1'b0;
        forever begin
            @(posedge clk);
            return_data_lines <= ~return_data_lines;
            if (any_line) begin
                rdl = {4'h0, junk};
                if (io_ctl.adrs) begin
                    n_adrs++;
                    dev_seen = io_ctl.dal;
                end
                if (io_ctl.data_request_line || io_ctl.data_output_line) begin
                    out_bytes[nbyte] = io_ctl.dal;
                    rdl = in_bytes[nbyte];
                    nbyte++;
                    polls = 0;
                end
                if (io_ctl.status_request_line) begin
                    n_stat++;
                    if (polls < busy_polls) begin
                        rdl[4] = 1'b1;
                        polls++;
                    end else if (nbyte - 1 == err_byte) begin
                        rdl[7:4] = err_stat[7:4];
                    end
                end
                repeat (lag) @(posedge clk);
                return_data_lines <= rdl;
                sync_response <= 1'b1;
                while (any_line) @(posedge clk);
                sync_response <= 1'b0;
            end
        end
    end
endmodule

/* File: testbench/block_io_transfer_sequencer_tb.sv */
`timescale 1ns/1ps
module block_io_transfer_sequencer_tb;
    import bits_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    bits_mem_req_type mem_req;
    logic [7:0] mem_rdata;
    bits_io_ctl_type io_ctl;
    logic [7:0] return_data_lines;
    logic sync_response;
    logic irq;
    logic [33:0] expq [$];
    int mismatches = 0;
    int comparisons = 0;
    int seed = 63;

    always #2 clk = ~clk;

    bits_seq dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .io_ctl(io_ctl), .return_data_lines(return_data_lines),
        .sync_response(sync_response), .irq(irq));

    bits_io_model m_u (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata), .io_ctl(io_ctl),
        .return_data_lines(return_data_lines), .sync_response(sync_response));

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        check(s_axi_bresp, RESP_OKAY);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
        expq.push_back(exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic put16(input logic [15:0] a, input logic [15:0] v);
        m_u.mem[a] = v[15:8];
        m_u.mem[a + 16'h1] = v[7:0];
    endtask

    task automatic run(input logic [2:0] ctl, input int bp, input int eb, input logic [7:0] es);
        m_u.busy_polls = bp;
        m_u.err_byte = eb;
        m_u.err_stat = es;
        m_u.polls = 0;
        m_u.nbyte = 0;
        m_u.n_adrs = 0;
        m_u.n_stat = 0;
        m_u.junk = $random(seed);
        for (int i = 0; i < 16; i++) m_u.in_bytes[i] = $random(seed);
        axi_wr(REG_CTRL, {29'h0, ctl});
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Each returned read is compared with the oldest expectation.
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
    end

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        axi_rd(REG_STAT, 34'h0);
        axi_rd(REG_IRQ, 34'h0);
        axi_rd(8'h20, {RESP_SLVERR, 32'h0});
        put16(16'h0100, 16'h0200);
        put16(16'h0102, 16'h0203);
        put16(16'h0110, 16'h0302);
        put16(16'h0120, 16'h0210);
        put16(16'h0122, 16'h0210);
        for (int i = 0; i < 3; i++) m_u.mem[16'h0300 + i] = $random(seed);
        axi_wr(REG_DEVNUM, 32'h5a);
        axi_wr(REG_END, 32'h100);
        axi_wr(REG_START, 32'h300);
        axi_wr(REG_MASK, 32'h3);
        // Block input with busy polling, plus a refused second go.
        m_u.lag = 1;
        run(3'b001, 2, -1, 8'h00);
        axi_wr(REG_CTRL, 32'h1);
        wait_irq();
        axi_rd(REG_STAT, 34'h0);
        axi_rd(REG_CUR, 34'h203);
        axi_rd(REG_IRQ, 34'h5);
        repeat (2) @(posedge clk);
        #1;
        check(irq, 34'h0);
        for (int i = 0; i < 4; i++) check(m_u.mem[16'h0200 + i], m_u.in_bytes[i]);
        check(m_u.n_adrs, 34'h1);
        check(m_u.dev_seen, 34'h5a);
        check(m_u.nbyte, 34'h4);
        check(m_u.n_stat, 34'hc);
        @(posedge clk);
        // Block output, register start form, slow controller.
        m_u.lag = 3;
        axi_wr(REG_END, 32'h110);
        run(3'b111, 0, -1, 8'h00);
        wait_irq();
        axi_rd(REG_STAT, 34'h0);
        axi_rd(REG_IRQ, 34'h1);
        axi_rd(REG_CUR, 34'h302);
        for (int i = 0; i < 3; i++) check(m_u.out_bytes[i], m_u.mem[16'h0300 + i]);
        check(m_u.nbyte, 34'h3);
        check(m_u.n_stat, 34'h3);
        // Each error bit ends the block after the second byte.
        axi_wr(REG_END, 32'h100);
        for (int b = 5; b < 8; b++) begin
            run(3'b001, 1, 1, 8'h01 << b);
            wait_irq();
            axi_rd(REG_STAT, 34'h1 << b);
            axi_rd(REG_IRQ, 34'h2);
            axi_rd(REG_CUR, 34'h201);
            check(m_u.nbyte, 34'h2);
        end
        // Single byte block with the interrupt masked.
        axi_wr(REG_MASK, 32'h0);
        axi_wr(REG_END, 32'h120);
        run(3'b001, 0, -1, 8'h00);
        repeat (300) @(posedge clk);
        check(irq, 34'h0);
        axi_rd(REG_CUR, 34'h210);
        check(m_u.mem[16'h0210], m_u.in_bytes[0]);
        axi_wr(REG_MASK, 32'h1);
        @(posedge clk);
        #1;
        check(irq, 34'h1);
        @(posedge clk);
        axi_rd(REG_IRQ, 34'h1);
        give_verdict();
    end
endmodule
